// ---- rtl/dcv_supervisor.sv ----
// DC bus voltage supervisor: thresholds, warnings, faults, parameters
//
// Function
// - Overvoltage warning level 16-bit, 0..900, zero=off
// - Overvoltage warning when voltage above nonzero level
// - Overvoltage fault level read-only, loaded from config
// - Read-only capacitor limit; exceed raises fault CAP_OVERLOAD_FAULT
// - Undervoltage fault level writable, 90..420, default 90
// - Policy 0: undervoltage fault regardless of enable
// - Policy 1: undervoltage fault only during enable attempt
// - Policy bit defaults to 1 after load
// - Undervoltage warning level, default fault level plus ten
// - Undervoltage warning when voltage below warning level
// - Measured bus voltage readable, feeds all but the capacitor comparison
`timescale 1ns/1ps
module dcv_supervisor
  import dcv_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Measurement side
  input  wire logic              sample_valid,
  input  wire logic [VOLT_W-1:0] bus_voltage,
  input  wire logic [VOLT_W-1:0] cap_load,
  // Drive enable attempts
  input  wire logic              sw_enable,
  input  wire logic              hw_enable_pin,
  // Configuration memory load
  input  wire logic              cfg_load,
  input  wire logic [VOLT_W-1:0] cfg_ovf_level,
  input  wire logic [VOLT_W-1:0] cfg_cap_limit,
  input  wire logic [VOLT_W-1:0] cfg_uvf_level,
  // Parameter access port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0]      reg_rdata,
  output logic                   reg_rvalid,
  // Nonvolatile save request
  output logic                   nv_save,
  output logic [ADDR_W-1:0]      nv_save_addr,
  output logic [VOLT_W-1:0]      nv_save_data,
  // Supervisor flags
  input  wire logic              fault_clear,
  output logic                   ov_warn,
  output logic                   uv_warn,
  output logic                   uv_fault,
  output logic                   cap_overload_fault,
  output logic [15:0]            fault_code
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [VOLT_W-1:0] ovw_level_q;     // Overvoltage warning level
  logic [VOLT_W-1:0] ovf_level_q;     // Overvoltage fault level, RO
  logic [VOLT_W-1:0] cap_limit_q;     // Capacitor load limit, RO
  logic [VOLT_W-1:0] uvf_level_q;     // Undervoltage fault level
  logic              uvf_pol_q;       // Undervoltage fault policy
  logic [VOLT_W-1:0] uvw_level_q;     // Undervoltage warning level
  logic [VOLT_W-1:0] volt_q;          // Last measured bus voltage
  logic              hw_en_meta_q;    // Synchroniser first stage
  logic              hw_en_q;         // Synchroniser second stage
  logic              ov_warn_q;       // Warning flags
  logic              uv_warn_q;
  logic              uv_fault_q;      // Sticky fault flags
  logic              cap_fault_q;
  logic [DATA_W-1:0] rdata_q;         // Read answer
  logic              rvalid_q;
  logic              nv_save_q;       // Save request pulse
  logic [ADDR_W-1:0] nv_addr_q;
  logic [VOLT_W-1:0] nv_data_q;

  // ------------------------------------------------------------------
  // Write decode and range limiting
  // ------------------------------------------------------------------
  wire logic [VOLT_W-1:0] wr_volt  = reg_wdata[VOLT_W-1:0];
  wire logic              wr_big   = |reg_wdata[DATA_W-1:VOLT_W];
  // Out of range writes are clamped rather than refused, so software
  // always ends with a legal level in place
  wire logic [VOLT_W-1:0] wr_full  =
    (wr_big || wr_volt > VOLT_MAX) ? VOLT_MAX : wr_volt;
  wire logic [VOLT_W-1:0] wr_uvf   =
    (wr_big || wr_volt > UVF_MAX) ? UVF_MAX :
    (wr_volt < UVF_MIN) ? UVF_MIN : wr_volt;
  wire logic              wr_ovw   = reg_wr && reg_addr == ADDR_OVW_LEVEL;
  wire logic              wr_uvf_l = reg_wr && reg_addr == ADDR_UVF_LEVEL;
  wire logic              wr_pol   = reg_wr && reg_addr == ADDR_UVF_POL;
  wire logic              wr_uvw   = reg_wr && reg_addr == ADDR_UVW_LEVEL;
  wire logic              wr_any   = wr_ovw | wr_uvf_l | wr_pol | wr_uvw;
  wire logic [VOLT_W-1:0] wr_saved =
    wr_uvf_l ? wr_uvf :
    wr_pol   ? {{(VOLT_W-1){1'b0}}, reg_wdata[0]} : wr_full;

  // ------------------------------------------------------------------
  // Threshold comparisons on the incoming sample
  // ------------------------------------------------------------------
  wire logic enable_try = sw_enable | hw_en_q;
  wire logic ov_cmp = (ovw_level_q != OVW_RESET)
                   && (bus_voltage > ovw_level_q);
  wire logic uv_cmp = bus_voltage < uvw_level_q;
  wire logic uvf_low = bus_voltage < uvf_level_q;
  // Policy 0 faults at any time, policy 1 only while enabling
  wire logic uvf_cmp = uvf_low &&
    ((uvf_pol_q == POL_ALWAYS) ||
     (uvf_pol_q == POL_ON_ENABLE && enable_try));
  wire logic cap_cmp = cap_load > cap_limit_q;
  wire logic uvf_set = sample_valid && uvf_cmp;
  wire logic cap_set = sample_valid && cap_cmp;

  // ------------------------------------------------------------------
  // Read decode; unmapped numbers answer zero
  // ------------------------------------------------------------------
  logic [VOLT_W-1:0] rd_sel;
  always_comb begin
    rd_sel = '0;
    case (reg_addr)
      ADDR_OVF_LEVEL: rd_sel = ovf_level_q;
      ADDR_OVW_LEVEL: rd_sel = ovw_level_q;
      ADDR_CAP_LIMIT: rd_sel = cap_limit_q;
      ADDR_UVF_LEVEL: rd_sel = uvf_level_q;
      ADDR_UVF_POL:   rd_sel = {{(VOLT_W-1){1'b0}}, uvf_pol_q};
      ADDR_UVW_LEVEL: rd_sel = uvw_level_q;
      ADDR_BUS_VOLT:  rd_sel = volt_q;
      default:        rd_sel = '0;
    endcase
  end

  // ------------------------------------------------------------------
  // Hardware enable pin synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_en_meta_q <= 1'b0;
      hw_en_q      <= 1'b0;
    end else begin
      hw_en_meta_q <= hw_enable_pin;
      hw_en_q      <= hw_en_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Read-only levels, loaded from configuration memory
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ovf_level_q <= OVF_RESET;
      cap_limit_q <= CAP_RESET;
    end else if (cfg_load) begin
      ovf_level_q <= cfg_ovf_level;
      cap_limit_q <= cfg_cap_limit;
    end
  end

  // ------------------------------------------------------------------
  // Writable levels; a load restores warning and policy defaults, fault level from cfg_uvf_level
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ovw_level_q <= OVW_RESET;
      uvf_level_q <= UVF_RESET;
      uvf_pol_q   <= UVF_POL_RESET;
      uvw_level_q <= UVW_RESET;
    end else if (cfg_load) begin
      ovw_level_q <= OVW_RESET;
      uvf_level_q <= cfg_uvf_level;
      uvf_pol_q   <= UVF_POL_RESET;
      // Carry dropped on purpose: a legal fault level plus the margin
      // stays well inside the sample width
      uvw_level_q <= VOLT_W'(cfg_uvf_level + UVW_MARGIN);
    end else begin
      if (wr_ovw) begin
        ovw_level_q <= wr_full;
      end
      if (wr_uvf_l) begin
        uvf_level_q <= wr_uvf;
      end
      if (wr_pol) begin
        uvf_pol_q <= reg_wdata[0];
      end
      if (wr_uvw) begin
        uvw_level_q <= wr_full;
      end
    end
  end

  // ------------------------------------------------------------------
  // Nonvolatile save request, one pulse per accepted write
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      nv_save_q <= 1'b0;
      nv_addr_q <= '0;
      nv_data_q <= '0;
    end else begin
      nv_save_q <= wr_any && !cfg_load;
      if (wr_any) begin
        nv_addr_q <= reg_addr;
        nv_data_q <= wr_saved;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sample capture and warning flags, updated once per sample
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      volt_q    <= '0;
      ov_warn_q <= 1'b0;
      uv_warn_q <= 1'b0;
    end else if (sample_valid) begin
      volt_q    <= bus_voltage;
      ov_warn_q <= ov_cmp;
      uv_warn_q <= uv_cmp;
    end
  end

  // ------------------------------------------------------------------
  // Sticky faults; a new event wins over a clear in the same cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      uv_fault_q  <= 1'b0;
      cap_fault_q <= 1'b0;
    end else begin
      uv_fault_q  <= uvf_set | (uv_fault_q & ~fault_clear);
      cap_fault_q <= cap_set | (cap_fault_q & ~fault_clear);
    end
  end

  // ------------------------------------------------------------------
  // Read answer, one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= {{(DATA_W-VOLT_W){1'b0}}, rd_sel};
      end
    end
  end

  // ------------------------------------------------------------------
  // Fault code register; only the capacitor fault carries a code here
  // ------------------------------------------------------------------
  logic [15:0] code_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      code_q <= NO_FAULT_CODE;
    end else begin
      code_q <= (cap_set | (cap_fault_q & ~fault_clear))
                ? CAP_FAULT_CODE : NO_FAULT_CODE;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign reg_rvalid         = rvalid_q;
  assign nv_save            = nv_save_q;
  assign nv_save_addr       = nv_addr_q;
  assign nv_save_data       = nv_data_q;
  assign ov_warn            = ov_warn_q;
  assign uv_warn            = uv_warn_q;
  assign uv_fault           = uv_fault_q;
  assign cap_overload_fault = cap_fault_q;
  assign fault_code         = code_q;

endmodule

// ---- rtl/dcv_pkg.sv ----
// Constants shared by the DC bus voltage supervisor
package dcv_pkg;

  // ------------------------------------------------------------------
  // Register port geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;                   // Parameter number width
  localparam int DATA_W = 32;                   // Parameter data width
  localparam int VOLT_W = 16;                   // Voltage sample width

  // ------------------------------------------------------------------
  // Parameter numbers (register indices)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_OVF_LEVEL = 12'h31a;
  localparam logic [ADDR_W-1:0] ADDR_OVW_LEVEL = 12'h31c;
  localparam logic [ADDR_W-1:0] ADDR_CAP_LIMIT = 12'h31e;
  localparam logic [ADDR_W-1:0] ADDR_UVF_LEVEL = 12'h320;
  localparam logic [ADDR_W-1:0] ADDR_UVF_POL   = 12'h322;
  localparam logic [ADDR_W-1:0] ADDR_UVW_LEVEL = 12'h324;
  localparam logic [ADDR_W-1:0] ADDR_BUS_VOLT  = 12'h326;

  // ------------------------------------------------------------------
  // Ranges and reset values, in volts
  // ------------------------------------------------------------------
  localparam logic [VOLT_W-1:0] VOLT_MAX       = 16'h0384; // 900 V
  localparam logic [VOLT_W-1:0] UVF_MIN        = 16'h005a; // 90 V
  localparam logic [VOLT_W-1:0] UVF_MAX        = 16'h01a4; // 420 V
  localparam logic [VOLT_W-1:0] OVW_RESET      = 16'h0000; // Warning off
  localparam logic [VOLT_W-1:0] UVF_RESET      = 16'h005a; // 90 V
  localparam logic [VOLT_W-1:0] UVW_MARGIN     = 16'h000a; // 10 V
  localparam logic [VOLT_W-1:0] UVW_RESET      = 16'h0064; // 90 V + 10 V
  localparam logic [VOLT_W-1:0] OVF_RESET      = 16'h0000; // Until loaded
  localparam logic [VOLT_W-1:0] CAP_RESET      = 16'hffff; // Until loaded
  localparam logic              UVF_POL_RESET  = 1'b1;     // Enable gated

  // ------------------------------------------------------------------
  // Policy encoding and fault code
  // ------------------------------------------------------------------
  localparam logic              POL_ALWAYS     = 1'b0;
  localparam logic              POL_ON_ENABLE  = 1'b1;
  localparam logic [15:0]       CAP_FAULT_CODE = 16'hf503;
  localparam logic [15:0]       NO_FAULT_CODE  = 16'h0000;

endpackage

// ---- test/dcv_assertions.sv ----
// Port-level assertions for the DC bus voltage supervisor
`timescale 1ns/1ps
module dcv_assertions
  import dcv_pkg::*;
(
  // Clock, reset and block inputs
  input logic              clk,
  input logic              srst,
  input logic              sample_valid,
  input logic [VOLT_W-1:0] bus_voltage,
  input logic              sw_enable,
  input logic              reg_rd,
  input logic              fault_clear,
  // Block outputs
  input logic              reg_rvalid,
  input logic              ov_warn,
  input logic              uv_warn,
  input logic              uv_fault,
  input logic              cap_overload_fault,
  input logic [15:0]       fault_code
);
  // One domain; reset masks every check
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_code_match: assert property (
    fault_code == (cap_overload_fault ? CAP_FAULT_CODE : NO_FAULT_CODE))
    else $error("fault code disagrees with capacitor fault");
  a_uv_stick: assert property (uv_fault && !fault_clear |=> uv_fault)
    else $error("undervoltage fault dropped without clear");
  // Writes clamp the fault level to the top of its range and a load is taken as legal, so
  // only such a sample may set the fault
  a_uv_cause: assert property (
    !uv_fault && !(sample_valid && bus_voltage < UVF_MAX) |=> !uv_fault)
    else $error("undervoltage fault set without low sample");
  // Below the lowest legal fault level with enable held: both policies set
  a_uv_enabled: assert property (
    sample_valid && bus_voltage < UVF_MIN && sw_enable |=> uv_fault)
    else $error("undervoltage fault missed during enable");
  a_ov_zero: assert property (
    sample_valid && bus_voltage == 16'h0000 |=> !ov_warn)
    else $error("overvoltage warning at zero volts");
  a_uvw_top: assert property (
    sample_valid && bus_voltage >= VOLT_MAX |=> !uv_warn)
    else $error("undervoltage warning at full scale");
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered in one cycle");
  a_warn_hold: assert property (
    !sample_valid |=> $stable({ov_warn, uv_warn}))
    else $error("warning changed without a sample");
  // Main scenarios reached
  c_uv_fault: cover property (sample_valid ##1 uv_fault);
  c_cap_fault: cover property (cap_overload_fault);
  c_ov_warn: cover property (ov_warn);
endmodule
bind dcv_supervisor dcv_assertions u_chk (.*);

// ---- test/dcv_meas_model.sv ----
// Behavioural bus voltage measurement source
`timescale 1ns/1ps
module dcv_meas_model
  import dcv_pkg::*;
(
  // Clock
  input  logic              clk,
  // Sample stream towards the block
  output logic              sample_valid,
  output logic [VOLT_W-1:0] bus_voltage,
  output logic [VOLT_W-1:0] cap_load
);
  // Idle: no strobe, data lines parked at a pattern
  initial {sample_valid, bus_voltage, cap_load} = {1'b0, 32'h5555_aaaa};
  // One strobe per sample; afterwards the data lines are inverted so a
  // block that reads them off the strobe sees garbage
  task automatic smp(logic [VOLT_W-1:0] v, logic [VOLT_W-1:0] c);
    @(negedge clk) {sample_valid, bus_voltage, cap_load} = {1'b1, v, c};
    @(negedge clk) {sample_valid, bus_voltage, cap_load} = {1'b0, ~v, ~c};
  endtask
endmodule

// ---- test/dcv_supervisor_test.sv ----
// Self-checking bench for the DC bus voltage supervisor
`timescale 1ns/1ps
module dcv_supervisor_test
  import dcv_pkg::*;
;
  // Stimulus, observed outputs and bookkeeping
  logic              clk = 1'b0, srst = 1'b1, sw_enable = 1'b0, f;
  logic              hw_enable_pin = 1'b0, cfg_load = 1'b0, reg_wr = 1'b0;
  logic              reg_rd = 1'b0, fault_clear = 1'b0, reg_rvalid, nv_save;
  logic              ov_warn, uv_warn, uv_fault, cap_overload_fault;
  logic              sample_valid;
  logic [ADDR_W-1:0] reg_addr = 12'h000, nv_save_addr;
  logic [DATA_W-1:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [VOLT_W-1:0] cfg_ovf_level = 16'h0320, cfg_cap_limit = 16'h0200;
  logic [VOLT_W-1:0] cfg_uvf_level = 16'h0096, nv_save_data, v, l;
  logic [VOLT_W-1:0] bus_voltage, cap_load, fault_code;
  int                mismatches = 0, checks_done = 0, seed = 89703;
  dcv_supervisor u_dut (.*);
  dcv_meas_model u_meas (.*);
  always #12.5 clk = ~clk;
  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #125000;
    mismatches++;
    close_out();
  end
  // Compare; flags arrive zero-extended so an unknown never matches
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register cycles start and end on the falling edge
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, e);
  endtask
  task automatic clr;
    @(negedge clk) fault_clear = 1'b1;
    @(negedge clk) fault_clear = 1'b0;
  endtask
  // Overvoltage warning: zero level means off, else strictly above
  function automatic logic ov_exp(logic [15:0] v, logic [15:0] l);
    return l != 16'h0000 && v > l;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    rd(ADDR_UVW_LEVEL, UVF_RESET + UVW_MARGIN);
    rd(12'h330, 32'h0000_0000);
    cfg_load = 1'b1;
    @(negedge clk) cfg_load = 1'b0;
    // Write to a read-only level: ignored, and no save request follows
    wr(ADDR_OVF_LEVEL, 32'h0000_0001);
    chk(nv_save, 1'b0);
    rd(ADDR_OVF_LEVEL, cfg_ovf_level);
    rd(ADDR_UVF_POL, POL_ON_ENABLE);
    u_meas.smp(VOLT_MAX, 16'h0000);
    chk(ov_warn, 1'b0);
    rd(ADDR_BUS_VOLT, VOLT_MAX);
    wr(ADDR_UVF_LEVEL, 32'h0001_0032);
    rd(ADDR_UVF_LEVEL, UVF_MAX);
    wr(ADDR_UVF_LEVEL, 32'h0000_0032);
    chk({nv_save, nv_save_data}, {1'b1, UVF_MIN});
    chk(nv_save_addr, ADDR_UVF_LEVEL);
    $display("register test done");
    // Enable-gated policy first, then unconditional
    u_meas.smp(16'h0050, 16'h0000);
    chk(uv_fault, 1'b0);
    hw_enable_pin = 1'b1;
    repeat (3) @(negedge clk);
    u_meas.smp(16'h0050, 16'h0201);
    chk({uv_fault, fault_code}, {1'b1, CAP_FAULT_CODE});
    clr();
    // Enable withdrawn so policy 0 must fault on its own
    hw_enable_pin = 1'b0;
    wr(ADDR_UVF_POL, 32'h0000_0000);
    u_meas.smp(16'h0059, 16'h0200);
    u_meas.smp(16'h012c, 16'h0000);
    chk({uv_fault, cap_overload_fault}, 2'b10);
    $display("fault test done");
    // Random levels and samples, with zero and equal-to-level corners
    clr();
    f = 1'b0;
    for (int i = 0; i < 40; i++) begin
      l = 16'($unsigned($random(seed)) % 901);
      v = (i == 1) ? l : 16'($unsigned($random(seed)) % (i ? 901 : 1));
      sw_enable = 1'($random(seed));
      wr(ADDR_OVW_LEVEL, {16'h0000, l});
      u_meas.smp(v, 16'h0000);
      f = f | (v < UVF_MIN);
      chk(ov_warn, ov_exp(v, l));
      chk(uv_warn, v < cfg_uvf_level + UVW_MARGIN);
      chk(uv_fault, f);
    end
    $display("random test done");
    close_out();
  end
endmodule
